// *** eic_ctrl.v ***
// Purpose: External and top-level interrupt front end with arbitration
// Assumes: AHB-Lite slave, core sequencer handshake on plain ports
// Notes:   Level 7 never wins; top-level service blocks all others
//
// Overview of operation
// RULE_01 - Eight external channels in four pairs, even and odd.
// RULE_02 - Edge bit 1 sets pending on rise, 0 on fall.
// RULE_03 - Per-channel mask bit gates only that channel's request.
// RULE_04 - Two-bit pair priority plus forced LSB: even 0, odd 1.
// RULE_05 - Channel A0 source: pin or timer/watchdog, by select bit.
// RULE_06 - A1,B0,B1,C0,C1,D0 each choose pin or on-chip peripheral.
// RULE_07 - Channel D1 source: unmaskable pin or wake-up line unit.
// RULE_08 - Top source select resets to pin; clear picks watchdog end.
// RULE_09 - Pin top source uses rising or falling edge per edge bit.
// RULE_10 - Selected top event sets top pending flag.
// RULE_11 - Maskable top request needs pending, top enable, global enable.
// RULE_12 - Unmaskable bit set-only, reset clears; ignores global enable.
// RULE_13 - Top service blocks every other request, top included.
// RULE_14 - Top entry and return keep global enable, level, hold reg.
// RULE_15 - Peripheral pending set by hardware, set or cleared by software.
// RULE_16 - Peripheral request needs mask, pending and global enable high.
// RULE_17 - Three-bit level, 0 highest; level 7 never acknowledged.
// RULE_18 - Each channel has vector pointer up to seven bits.
// RULE_19 - Arbitration samples every five cycles; acknowledge adds one.
// RULE_20 - Sources hold levels one irq clock, edge before sampling.
// RULE_21 - Abort instruction if no write done, else finish first.
// RULE_22 - Entry takes 18 cycles, +2 stack in file, +2 segment push.
// RULE_23 - External response 26..55 cycles, top 22..51 cycles.
// RULE_24 - Acknowledge clears the channel pending; software may set it.
// RULE_25 - Top acknowledge clears top pending; software may set it.
// RULE_26 - Pick lowest enabled pending level, compare with current level.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "eic_defines.vh"
module eic_ctrl #(
  parameter NCH = 8 // RULE_01
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Interrupt sources
  input  wire [6:0]  ext_pin,
  input  wire        nmi_pin,
  input  wire        wdg_end_count,
  input  wire [6:0]  periph_event,
  input  wire        wakeup_line_unit,
  // Core sequencer
  input  wire        instr_wrote,
  input  wire        stack_in_file,
  input  wire        iret_done,
  output reg         irq_req,
  output reg         irq_top,
  output reg  [2:0]  irq_level,
  output reg  [6:0]  irq_vector,
  output reg         instr_abort,
  output reg  [4:0]  entry_cycles
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ACK  = 2'd1;
  localparam ST_SERV = 2'd2;

  reg  [7:0] central_irq_ctrl;
  reg  [7:0] edge_select_reg;
  reg  [7:0] ext_pending_reg;
  reg  [7:0] ext_mask_reg;
  reg  [7:0] pair_priority_reg;
  reg  [3:0] ext_vector_reg;
  reg  [3:0] vec_high_reg;
  reg  [7:0] nested_hold_reg;
  reg  [6:0] src_sel_reg;
  reg        segment_push_enable;
  reg  [1:0] state_reg;
  reg  [2:0] arb_cnt_reg;
  reg  [3:0] win_ch_reg;
  reg        top_serv_reg;
  reg        dph_reg;
  reg        dwr_reg;
  reg  [11:0] daddr_reg;

  wire [8:0] line_in;
  wire [8:0] rise_sel;
  wire [8:0] edge_pulse;
  wire [7:0] chan_src;
  wire [7:0] chan_req;
  wire       top_req;
  wire       top_event;
  wire       wr_en;
  wire       gie;
  wire [2:0] cur_level;
  reg  [2:0] best_lvl;
  reg  [3:0] best_ch;
  reg        best_ok;
  wire [31:0] entry_sum;
  integer    i;

  // Level of channel c from its pair field and forced parity bit
  function [2:0] chan_level;
    input [7:0] prio;
    input [2:0] c;
    begin
      chan_level = {prio[{c[2:1], 1'b1}], prio[{c[2:1], 1'b0}], c[0]}; // RULE_04
    end
  endfunction

  assign gie       = central_irq_ctrl[`EIC_CEN_GIE];
  assign cur_level = central_irq_ctrl[2:0];

  // Source selection per channel
  assign chan_src[0] = ext_vector_reg[`EIC_VEC_A0_SRC] ?
                       ext_pin[0] : wdg_end_count; // RULE_05
  genvar g;
  generate
    for (g = 1; g < 7; g = g + 1) begin : g_src
      assign chan_src[g] = src_sel_reg[g] ? periph_event[g] : ext_pin[g]; // RULE_06
    end
  endgenerate
  assign chan_src[7] = src_sel_reg[0] ? wakeup_line_unit : nmi_pin; // RULE_07

  assign line_in  = {nmi_pin, chan_src};
  assign rise_sel = {ext_vector_reg[`EIC_VEC_TOP_EDGE], edge_select_reg};
  // Entry length summed wide, then cut to the five-bit port
  assign entry_sum = `EIC_ENTRY_BASE +
                     (stack_in_file ? `EIC_ENTRY_STACK : 0) +
                     (segment_push_enable ? `EIC_ENTRY_SEG : 0); // RULE_22

  eic_edge_detect #(.N(9)) u_edge (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .line_in    (line_in),
    .rise_sel   (rise_sel),
    .edge_pulse (edge_pulse)
  ); // RULE_02 RULE_09

  // Top event: pin edge or watchdog end of count
  assign top_event = ext_vector_reg[`EIC_VEC_TOP_SRC] ?
                     edge_pulse[8] : (wdg_end_count & clk_en); // RULE_08

  assign chan_req = ext_pending_reg & ext_mask_reg & {NCH{gie}}; // RULE_03 RULE_16
  assign top_req  = central_irq_ctrl[`EIC_CEN_TOP_PEND] &
                    (nested_hold_reg[`EIC_NEST_UNMASK] |
                     (central_irq_ctrl[`EIC_CEN_TOP_EN] & gie)); // RULE_11 RULE_12

  // Highest priority enabled request
  always @* begin
    best_lvl = `EIC_LVL_NEVER;
    best_ch  = 4'h0;
    best_ok  = 1'b0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (chan_req[i] &&
          chan_level(pair_priority_reg, i[2:0]) != `EIC_LVL_NEVER &&
          chan_level(pair_priority_reg, i[2:0]) <= best_lvl) begin
        best_lvl = chan_level(pair_priority_reg, i[2:0]);
        best_ch  = i[3:0];
        best_ok  = 1'b1;
      end
    end
    best_ok = best_ok & (best_lvl < cur_level); // RULE_17 RULE_26
  end

  // Bus slave
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dph_reg & dwr_reg & clk_en;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_reg   <= 1'b0;
      dwr_reg   <= 1'b0;
      daddr_reg <= 12'h000;
    end else if (clk_en && hready) begin
      dph_reg   <= hsel & htrans[1];
      dwr_reg   <= hwrite;
      daddr_reg <= haddr;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (clk_en && hsel && htrans[1] && !hwrite && hready) begin
      if (haddr == `EIC_OFS_CENTRAL)
        hrdata <= {24'h000000, central_irq_ctrl};
      else if (haddr == `EIC_OFS_EDGE)
        hrdata <= {24'h000000, edge_select_reg};
      else if (haddr == `EIC_OFS_PEND)
        hrdata <= {24'h000000, ext_pending_reg};
      else if (haddr == `EIC_OFS_MASK)
        hrdata <= {24'h000000, ext_mask_reg};
      else if (haddr == `EIC_OFS_PRIO)
        hrdata <= {24'h000000, pair_priority_reg};
      else if (haddr == `EIC_OFS_VECT)
        hrdata <= {24'h000000, vec_high_reg, ext_vector_reg};
      else if (haddr == `EIC_OFS_NEST)
        hrdata <= {24'h000000, nested_hold_reg};
      else if (haddr == `EIC_OFS_SRCSEL)
        hrdata <= {25'h0000000, src_sel_reg};
      else if (haddr == `EIC_OFS_CORE)
        hrdata <= {31'h00000000, segment_push_enable};
      else if (haddr == `EIC_OFS_STATUS)
        hrdata <= {26'h0000000, top_serv_reg, state_reg, arb_cnt_reg};
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Registers, pending flags and arbitration sequencer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      central_irq_ctrl    <= `EIC_RST_CENTRAL;
      edge_select_reg     <= `EIC_RST_EDGE;
      ext_pending_reg     <= `EIC_RST_PEND;
      ext_mask_reg        <= `EIC_RST_MASK;
      pair_priority_reg   <= `EIC_RST_PRIO;
      ext_vector_reg      <= `EIC_RST_VECT;
      vec_high_reg        <= 4'h0;
      nested_hold_reg     <= `EIC_RST_NEST;
      src_sel_reg         <= `EIC_RST_SRCSEL;
      segment_push_enable <= 1'b0;
      state_reg           <= ST_IDLE;
      arb_cnt_reg         <= 3'h0;
      win_ch_reg          <= 4'h0;
      top_serv_reg        <= 1'b0;
      irq_req             <= 1'b0;
      irq_top             <= 1'b0;
      irq_level           <= 3'h0;
      irq_vector          <= 7'h00;
      instr_abort         <= 1'b0;
      entry_cycles        <= 5'h00;
    end else if (clk_en) begin
      if (wr_en) begin
        if (daddr_reg == `EIC_OFS_CENTRAL)
          central_irq_ctrl <= hwdata[7:0];
        else if (daddr_reg == `EIC_OFS_EDGE)
          edge_select_reg <= hwdata[7:0];
        else if (daddr_reg == `EIC_OFS_PEND)
          ext_pending_reg <= hwdata[7:0]; // RULE_15 RULE_24
        else if (daddr_reg == `EIC_OFS_MASK)
          ext_mask_reg <= hwdata[7:0];
        else if (daddr_reg == `EIC_OFS_PRIO)
          pair_priority_reg <= hwdata[7:0];
        else if (daddr_reg == `EIC_OFS_VECT) begin
          vec_high_reg   <= hwdata[7:4];
          ext_vector_reg <= hwdata[3:0];
        end else if (daddr_reg == `EIC_OFS_NEST)
          nested_hold_reg <= {nested_hold_reg[7] | hwdata[7],
                              hwdata[6:0]}; // RULE_12
        else if (daddr_reg == `EIC_OFS_SRCSEL)
          src_sel_reg <= hwdata[6:0];
        else if (daddr_reg == `EIC_OFS_CORE)
          segment_push_enable <= hwdata[0];
      end
      // Hardware sets win over software clear
      ext_pending_reg[7:0] <= ((wr_en && daddr_reg == `EIC_OFS_PEND) ?
                               hwdata[7:0] : ext_pending_reg) |
                              edge_pulse[7:0]; // RULE_02 RULE_15
      if (top_event)
        central_irq_ctrl[`EIC_CEN_TOP_PEND] <= 1'b1; // RULE_10
      instr_abort <= 1'b0;
      irq_req     <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          arb_cnt_reg <= (arb_cnt_reg == `EIC_ARB_PERIOD - 1) ?
                         3'h0 : arb_cnt_reg + 3'h1; // RULE_19
          if (arb_cnt_reg == `EIC_ARB_PERIOD - 1 && !top_serv_reg) begin // RULE_13
            if (top_req) begin
              irq_top   <= 1'b1;
              state_reg <= ST_ACK;
            end else if (best_ok) begin
              irq_top    <= 1'b0;
              win_ch_reg <= best_ch;
              irq_level  <= best_lvl;
              state_reg  <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          // One extra cycle to acknowledge
          irq_req      <= 1'b1; // RULE_19 RULE_23
          instr_abort  <= ~instr_wrote; // RULE_21
          entry_cycles <= entry_sum[4:0]; // RULE_22
          if (irq_top) begin
            central_irq_ctrl[`EIC_CEN_TOP_PEND] <= top_event; // RULE_25
            top_serv_reg <= 1'b1; // RULE_14
            irq_vector   <= 7'h00;
          end else begin
            ext_pending_reg[win_ch_reg[2:0]] <=
              edge_pulse[win_ch_reg[2:0]]; // RULE_24
            irq_vector <= {vec_high_reg, win_ch_reg[2:0]}; // RULE_18
            central_irq_ctrl[`EIC_CEN_GIE] <= 1'b0;
            if (central_irq_ctrl[`EIC_CEN_NESTED]) begin
              nested_hold_reg[cur_level] <= 1'b1;
              central_irq_ctrl[2:0]      <= irq_level;
            end
          end
          state_reg <= ST_SERV;
        end
        default: begin
          // Return: top leaves enable and levels untouched
          if (iret_done) begin
            if (top_serv_reg)
              top_serv_reg <= 1'b0; // RULE_14
            else
              central_irq_ctrl[`EIC_CEN_GIE] <= 1'b1;
            state_reg   <= ST_IDLE;
            arb_cnt_reg <= 3'h0;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** eic_defines.vh ***
// Purpose: Shared constants for the external and top-level interrupt block
// Assumes: AHB-Lite word registers, 50 MHz system clock
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH

`define EIC_OFS_CENTRAL    12'h000
`define EIC_OFS_EDGE       12'h004
`define EIC_OFS_PEND       12'h008
`define EIC_OFS_MASK       12'h00c
`define EIC_OFS_PRIO       12'h010
`define EIC_OFS_VECT       12'h014
`define EIC_OFS_NEST       12'h018
`define EIC_OFS_SRCSEL     12'h01c
`define EIC_OFS_CORE       12'h020
`define EIC_OFS_ACK        12'h024
`define EIC_OFS_STATUS     12'h028

`define EIC_RST_CENTRAL    8'h87
`define EIC_RST_EDGE       8'h00
`define EIC_RST_PEND       8'h00
`define EIC_RST_MASK       8'h00
`define EIC_RST_PRIO       8'hff
`define EIC_RST_VECT       4'h6
`define EIC_RST_NEST       8'h00
`define EIC_RST_SRCSEL     7'h00

`define EIC_CEN_TOP_PEND   6
`define EIC_CEN_TOP_EN     5
`define EIC_CEN_GIE        4
`define EIC_CEN_NESTED     3
`define EIC_VEC_TOP_EDGE   3
`define EIC_VEC_TOP_SRC    2
`define EIC_VEC_A0_SRC     1
`define EIC_NEST_UNMASK    7

`define EIC_ARB_PERIOD     5
`define EIC_ACK_EXTRA      1
`define EIC_ENTRY_BASE     18
`define EIC_ENTRY_STACK    2
`define EIC_ENTRY_SEG      2
`define EIC_RESP_EXT_MIN   26
`define EIC_RESP_EXT_MAX   55
`define EIC_RESP_TOP_MIN   22
`define EIC_RESP_TOP_MAX   51
`define EIC_LVL_NEVER      3'h7

`endif

// *** eic_edge_detect.v ***
// Purpose: Edge detectors with selectable polarity, one per source line
// Assumes: Inputs synchronous to sys_clk
// Notes:   Pulse for one cycle on the selected edge
`timescale 1ns/1ns
`default_nettype none
module eic_edge_detect #(
  parameter N = 9
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire         clk_en,
  // Lines
  input  wire [N-1:0] line_in,
  input  wire [N-1:0] rise_sel,
  output wire [N-1:0] edge_pulse
);
  reg [N-1:0] prev_reg;
  genvar g;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      prev_reg <= {N{1'b0}};
    else if (clk_en)
      prev_reg <= line_in;
  end

  generate
    for (g = 0; g < N; g = g + 1) begin : g_edge
      assign edge_pulse[g] = clk_en & (rise_sel[g] ?
        (line_in[g] & ~prev_reg[g]) : (~line_in[g] & prev_reg[g]));
    end
  endgenerate
endmodule
`default_nettype wire

// *** eic_ctrl_assertions.sv ***
// Purpose: Port-level checks on the interrupt request side of eic_ctrl
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to eic_ctrl from the bench top file
`timescale 1ns/1ns
`default_nettype none
module eic_ctrl_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Core sequencer
  input wire logic       instr_wrote,
  input wire logic       stack_in_file,
  input wire logic       iret_done,
  input wire logic       irq_req,
  input wire logic       irq_top,
  input wire logic [2:0] irq_level,
  input wire logic [6:0] irq_vector,
  input wire logic       instr_abort,
  input wire logic [4:0] entry_cycles
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Tracks top service, so any request before the return is caught
  logic top_serv_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      top_serv_reg <= 1'b0;
    else if (irq_req && irq_top)
      top_serv_reg <= 1'b1;
    else if (iret_done)
      top_serv_reg <= 1'b0;
  end

  sequence s_ext_req;
    irq_req && !irq_top;
  endsequence
  sequence s_top_req;
    irq_req && irq_top;
  endsequence
  sequence s_quiet;
    !irq_req [*4];
  endsequence

  chk_abort_cause: assert property (instr_abort |-> irq_req)
    else $error("abort without request");
  chk_abort_clean: assert property (
    irq_req && !instr_wrote |-> instr_abort)
    else $error("clean instruction not aborted");
  chk_finish_write: assert property (
    irq_req && instr_wrote |-> !instr_abort)
    else $error("written instruction aborted");
  chk_arb_spacing: assert property (irq_req |=> s_quiet)
    else $error("requests closer than one arbitration pass");
  chk_lvl7_never: assert property (
    s_ext_req |-> irq_level != 3'h7)
    else $error("level seven acknowledged");
  chk_pair_lsb: assert property (
    s_ext_req |-> irq_level[0] == irq_vector[0])
    else $error("level lsb differs from channel parity");
  chk_top_vector: assert property (
    s_top_req |-> irq_vector == 7'h00)
    else $error("top request with channel vector");
  chk_top_blocks: assert property (top_serv_reg |-> !irq_req)
    else $error("request during top service");
  chk_entry_plain: assert property (
    irq_req && !stack_in_file |-> entry_cycles inside {5'd18, 5'd20})
    else $error("entry length wrong without stack in file");
  chk_entry_stack: assert property (
    irq_req && stack_in_file |-> entry_cycles inside {5'd20, 5'd22})
    else $error("entry length wrong with stack in file");
endmodule
`default_nettype wire

// *** eic_core_model.sv ***
// Purpose: Core sequencer stand-in that services requests and returns
// Assumes: Service length set by the bench before each request
// Notes:   Long services give room to probe blocking behaviour
`timescale 1ns/1ns
`default_nettype none
module eic_core_model (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Request side
  input wire logic       irq_req,
  input wire logic [7:0] serv_len,
  output var logic       iret_done
);
  logic [7:0] cnt_reg;
  logic       busy_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      iret_done <= 1'b0;
    end else begin
      iret_done <= 1'b0;
      if (irq_req) begin
        busy_reg <= 1'b1;
        cnt_reg <= serv_len;
      end else if (busy_reg && cnt_reg == 8'h00) begin
        busy_reg <= 1'b0;
        iret_done <= 1'b1;
      end else if (busy_reg)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** eic_ctrl_bench.sv ***
// Purpose: Register and request level tests of eic_ctrl
// Assumes: Zero-wait bus slave, core model returns after serv_len
// Notes:   Pins held four cycles so every edge is seen
`timescale 1ns/1ns
`default_nettype none
`include "eic_defines.vh"
module eic_ctrl_bench;
  logic        sys_clk, rst_n, clk_en, hsel, hwrite, nmi_pin, wdg, wake;
  logic        instr_wrote, stack_in_file, seen, ab;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [11:0] haddr;
  logic [31:0] hwdata, rd;
  logic [6:0]  ext_pin, periph_event;
  logic [7:0]  serv_len;
  wire         hreadyout, hresp, irq_req, irq_top, instr_abort, iret_done;
  wire  [2:0]  irq_level;
  wire  [6:0]  irq_vector;
  wire  [4:0]  entry_cycles;
  wire  [31:0] hrdata;
  int          mismatches, n_checks;

  always #10 sys_clk = ~sys_clk;

  eic_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_pin(ext_pin), .nmi_pin(nmi_pin), .wdg_end_count(wdg),
    .periph_event(periph_event), .wakeup_line_unit(wake),
    .instr_wrote(instr_wrote), .stack_in_file(stack_in_file),
    .iret_done(iret_done), .irq_req(irq_req), .irq_top(irq_top),
    .irq_level(irq_level), .irq_vector(irq_vector),
    .instr_abort(instr_abort), .entry_cycles(entry_cycles));
  eic_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .irq_req(irq_req), .serv_len(serv_len), .iret_done(iret_done));

  task cmp(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e, m);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, rd & m);
  endtask

  // Catches a single-cycle request pulse once its edge has settled
  task wait_req(input int n);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge sys_clk);
      #1;
      if (irq_req === 1'b1) begin
        seen = 1'b1;
        ab = instr_abort;
      end
    end
  endtask

  task quiet_iret(input int n);
    int stray;
    stray = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1;
      if (irq_req !== 1'b0)
        stray++;
      if (iret_done === 1'b1)
        break;
    end
    cmp("stray req", 32'h0, stray);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {sys_clk, rst_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {ext_pin, nmi_pin, wdg, periph_event, wake} = '0;
    {instr_wrote, stack_in_file, seen, ab} = '0;
    clk_en = 1'b1;
    serv_len = 8'd40;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rchk("central", `EIC_OFS_CENTRAL, 32'h87, 32'hff);
    rchk("vector", `EIC_OFS_VECT, 32'h6, 32'hf);
    rchk("prio", `EIC_OFS_PRIO, 32'hff, 32'hff);
    rchk("nest", `EIC_OFS_NEST, 32'h0, 32'hff);
    bus(1'b1, 12'h02c, 32'hff);
    rchk("unmapped", 12'h02c, 32'h0, 32'hffffffff);
    // Top request from the watchdog while the pin stays quiet
    bus(1'b1, `EIC_OFS_MASK, 32'hff);
    bus(1'b1, `EIC_OFS_PRIO, 32'hc1);
    bus(1'b1, `EIC_OFS_CENTRAL, 32'h37);
    bus(1'b1, `EIC_OFS_VECT, 32'ha2);
    wdg <= 1'b1;
    @(posedge sys_clk);
    wdg <= 1'b0;
    wait_req(30);
    cmp("top flag", 32'h1, {31'h0, irq_top & seen});
    cmp("top abort", 32'h1, {31'h0, ab});
    cmp("top entry", 32'd18, {27'h0, entry_cycles});
    rchk("central", `EIC_OFS_CENTRAL, 32'h37, 32'hff);
    bus(1'b1, `EIC_OFS_PEND, 32'h03);
    bus(1'b1, `EIC_OFS_CORE, 32'h1);
    stack_in_file <= 1'b1;
    instr_wrote <= 1'b1;
    serv_len <= 8'd8;
    quiet_iret(60);
    wait_req(30);
    cmp("a0 vector", 32'h50, {25'h0, irq_vector});
    cmp("a0 level", 32'd2, {29'h0, irq_level});
    cmp("a0 abort", 32'h0, {31'h0, ab});
    cmp("a0 entry", 32'd22, {27'h0, entry_cycles});
    rchk("pend", `EIC_OFS_PEND, 32'h02, 32'hff);
    bus(1'b1, `EIC_OFS_CENTRAL, 32'h17);
    wait_req(40);
    cmp("a1 vector", 32'h51, {25'h0, irq_vector});
    cmp("a1 level", 32'd3, {29'h0, irq_level});
    rchk("pend", `EIC_OFS_PEND, 32'h0, 32'hff);
    // Masked channel and level seven both stay silent
    bus(1'b1, `EIC_OFS_MASK, 32'hfe);
    bus(1'b1, `EIC_OFS_CENTRAL, 32'h17);
    bus(1'b1, `EIC_OFS_PEND, 32'h81);
    wait_req(30);
    cmp("masked", 32'h0, {31'h0, seen});
    bus(1'b1, `EIC_OFS_MASK, 32'hff);
    wait_req(30);
    cmp("unmasked", 32'h50, {25'h0, irq_vector});
    bus(1'b1, `EIC_OFS_PEND, 32'h0);
    // Return first, or the return would set the global enable again
    quiet_iret(60);
    // Pin edges with the global enable off
    bus(1'b1, `EIC_OFS_CENTRAL, 32'h07);
    bus(1'b1, `EIC_OFS_VECT, 32'ha6);
    bus(1'b1, `EIC_OFS_EDGE, 32'h55);
    {ext_pin, nmi_pin} <= 8'hff;
    repeat (4) @(posedge sys_clk);
    rchk("pend rise", `EIC_OFS_PEND, 32'h55, 32'hff);
    {ext_pin, nmi_pin} <= 8'h00;
    repeat (4) @(posedge sys_clk);
    rchk("pend fall", `EIC_OFS_PEND, 32'hff, 32'hff);
    rchk("top pend", `EIC_OFS_CENTRAL, 32'h47, 32'hff);
    bus(1'b1, `EIC_OFS_NEST, 32'h80);
    wait_req(30);
    cmp("unmaskable", 32'h1, {31'h0, irq_top & seen});
    rchk("top clear", `EIC_OFS_CENTRAL, 32'h07, 32'hff);
    bus(1'b1, `EIC_OFS_NEST, 32'h0);
    rchk("nest", `EIC_OFS_NEST, 32'h80, 32'h80);
    // Internal sources replace the pins
    bus(1'b1, `EIC_OFS_PEND, 32'h0);
    bus(1'b1, `EIC_OFS_SRCSEL, 32'h7f);
    bus(1'b1, `EIC_OFS_VECT, 32'ha4);
    bus(1'b1, `EIC_OFS_EDGE, 32'hff);
    {ext_pin, nmi_pin} <= 8'hff;
    repeat (4) @(posedge sys_clk);
    rchk("pins off", `EIC_OFS_PEND, 32'h0, 32'hff);
    {periph_event, wdg, wake} <= 9'h1ff;
    repeat (4) @(posedge sys_clk);
    rchk("internal", `EIC_OFS_PEND, 32'hff, 32'hff);
    {ext_pin, nmi_pin, periph_event, wdg, wake} <= '0;
    repeat (20) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule

bind eic_ctrl eic_ctrl_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .instr_wrote(instr_wrote), .stack_in_file(stack_in_file),
  .iret_done(iret_done), .irq_req(irq_req), .irq_top(irq_top),
  .irq_level(irq_level), .irq_vector(irq_vector),
  .instr_abort(instr_abort), .entry_cycles(entry_cycles));
`default_nettype wire
